//--- shared/mcs_consts.svh
// Constants for the motion card supervisor
`ifndef MCS_CONSTS_SVH
`define MCS_CONSTS_SVH
`define MCS_ADDR_W        4
`define MCS_DATA_W        32
`define MCS_ADDR_CTRL     4'h0
`define MCS_ADDR_TIMEOUT  4'h1
`define MCS_ADDR_STATUS   4'h2
`define MCS_ADDR_SWITCH   4'h3
`define MCS_ADDR_FETCH    4'h4
`define MCS_ADDR_NODES    4'h5
`define MCS_ADDR_LINK     4'h6
`define MCS_ADDR_SWITCH_N 4'h7
`define MCS_CTRL_WD_EN    0
`define MCS_CTRL_PWR_REQ  1
`define MCS_CTRL_RUNNING  2
`define MCS_CTRL_BOOTED   3
`define MCS_CTRL_BUS_ERR  4
`define MCS_TIMEOUT_RST   32'h000F_4240
`define MCS_JOINTS        6
`define MCS_NODES         16
`define MCS_BLINK_US      250000
`define MCS_CLK_MHZ       100
`define MCS_BLINK_CYC     (`MCS_BLINK_US * `MCS_CLK_MHZ)
`define MCS_NODE_MISS_MAX 4'h3
`endif

//--- shared/mcs_pkg.sv
// Types shared by the motion card supervisor
package mcs_pkg;
  typedef enum logic [2:0] {
    MCS_LED_OFF   = 3'b001,
    MCS_LED_ON    = 3'b010,
    MCS_LED_BLINK = 3'b100
  } mcs_led_e;
endpackage

//--- shared/mcs_node_if.sv
// Expander node supervision signals between top and node tracker
`timescale 1ns/1ps
interface mcs_node_if;
  logic        poll_valid;
  logic [3:0]  poll_addr;
  logic        poll_answered;
  logic [15:0] present;
  logic [15:0] active;
  logic        init_busy;
  logic        dropped;
  modport tracker (input poll_valid, poll_addr, poll_answered,
                   output present, active, init_busy, dropped);
  modport top (output poll_valid, poll_addr, poll_answered,
               input present, active, init_busy, dropped);
endinterface

//--- design/mcs_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module mcs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } mcs_sync_s;
  mcs_sync_s st_reg;
  mcs_sync_s st_next;
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      // Level moves only once stages two and three agree
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.lvl[i] = st_reg.s3[i];
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign level_out = st_reg.lvl;
endmodule

//--- design/mcs_node_track.sv
// Expander node presence and drop-out tracker
`timescale 1ns/1ps
`include "mcs_consts.svh"
module mcs_node_track import mcs_pkg::*; (
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  mcs_node_if.tracker nif
);
  typedef struct packed {
    logic [15:0]      present;
    logic [15:0]      active;
    logic [15:0][3:0] miss;
    logic [15:0]      seen_poll;
  } mcs_trk_s;
  mcs_trk_s st_reg;
  mcs_trk_s st_next;
  always_comb begin
    st_next = st_reg;
    if (nif.poll_valid) begin
      st_next.seen_poll[nif.poll_addr] = 1'b1;
      if (nif.poll_answered) begin
        st_next.present[nif.poll_addr] = 1'b1; // R15
        st_next.active[nif.poll_addr]  = 1'b1;
        st_next.miss[nif.poll_addr]    = 4'h0;
      end else if (st_reg.active[nif.poll_addr]) begin
        if (st_reg.miss[nif.poll_addr] == `MCS_NODE_MISS_MAX) begin
          st_next.active[nif.poll_addr] = 1'b0; // R16
        end else begin
          st_next.miss[nif.poll_addr] = st_reg.miss[nif.poll_addr] + 4'h1;
        end
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign nif.present   = st_reg.present;
  assign nif.active    = st_reg.active;
  // Init phase lasts until every address has been polled once
  assign nif.init_busy = ~&st_reg.seen_poll;
  assign nif.dropped   = |(st_reg.present & ~st_reg.active);
  AST_NODE_DROP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R16
    nif.poll_valid && !nif.poll_answered && st_reg.active[nif.poll_addr]
    && st_reg.miss[nif.poll_addr] == `MCS_NODE_MISS_MAX
    |=> !st_reg.active[$past(nif.poll_addr)])
    else $error("Node not dropped after missed polls");
  AST_NODE_FOUND: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R15
    nif.poll_valid && nif.poll_answered |=> st_reg.present[$past(nif.poll_addr)])
    else $error("Answering node not recorded");
endmodule

//--- design/mcs_supervisor.sv
// Motion card supervisor: watchdog, switch sampling, status lamps, node watch
//
// Overview of operation
// [R1] Periodic input fetch restarts watchdog count
// [R2] Expiry forces all amplifier enables low
// [R3] Readable flag shows watchdog expired
// [R4] Host bit enables or disables watchdog
// [R5] Host sets longest allowed fetch interval
// [R6] Host sets timeout near three servo periods
// [R7] Six joints' travel and reference switches sampled
// [R8] Switch states given true and complemented
// [R9] Two stop inputs given true and complemented
// [R10] Fieldbus lamp: blink traffic, lit full, dark
// [R11] Serial lamp: blink init, lit ok, dark drop
// [R12] Running lamp blinks while host software runs
// [R13] Boot lamp lit only after good boot
// [R14] Error lamp: dark, blink bus error, lit expired
// [R15] Expander nodes detected automatically
// [R16] Silent expander node removed from service
// [R17] Node without good frames enters error state; not modelled, a silent node is only dropped after missed polls
// [R18] Nodes carry unique four-bit addresses
// [R19] Enable needs request, live watchdog, no fault
// [R20] Expiry holds until watchdog re-enabled; here a control write with the enable bit low clears it
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "mcs_consts.svh"
module mcs_supervisor import mcs_pkg::*; (
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic [`MCS_ADDR_W-1:0]    addr_in,
  input  wire logic [`MCS_DATA_W-1:0]    wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [`MCS_DATA_W-1:0]    rdata_out,
  input  wire logic [`MCS_JOINTS-1:0]    lower_travel_switch_pin_in,
  input  wire logic [`MCS_JOINTS-1:0]    upper_travel_switch_pin_in,
  input  wire logic [`MCS_JOINTS-1:0]    reference_switch_pin_in,
  input  wire logic [1:0]                estop_pin_in,
  input  wire logic                      power_fault_pin_in,
  input  wire logic                      fieldbus_frame_in,
  input  wire logic                      fieldbus_full_in,
  input  wire logic                      node_poll_valid_in,
  input  wire logic [3:0]                node_poll_addr_in,
  input  wire logic                      node_poll_answered_in,
  output logic                           amp_enable_out,
  output logic                           fieldbus_led_out,
  output logic                           serial_led_out,
  output logic                           host_running_led_out,
  output logic                           boot_led_out,
  output logic                           error_led_out
);
  typedef struct packed {
    logic        wd_en;
    logic        pwr_req;
    logic        running;
    logic        booted;
    logic        bus_err;
    logic [31:0] timeout;
    logic [31:0] wd_cnt;
    logic        expired;
    logic [5:0]  low_sw;
    logic [5:0]  up_sw;
    logic [5:0]  ref_sw;
    logic [1:0]  estop;
    logic [31:0] blink_cnt;
    logic        blink;
    logic        fb_traffic;
    logic [31:0] rdata;
    logic        amp_en;
    logic        led_fb;
    logic        led_ser;
    logic        led_run;
    logic        led_boot;
    logic        led_err;
  } mcs_top_s;
  mcs_top_s st_reg;
  mcs_top_s st_next;
  logic [5:0]  low_lvl;
  logic [5:0]  up_lvl;
  logic [5:0]  ref_lvl;
  logic [1:0]  estop_lvl;
  logic        fault_lvl;
  logic        fetch;
  mcs_node_if  nif ();
  mcs_sync #(.W(3 * `MCS_JOINTS + 3)) u_sync (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    ({lower_travel_switch_pin_in, upper_travel_switch_pin_in,
                 reference_switch_pin_in, estop_pin_in, power_fault_pin_in}),
    .level_out ({low_lvl, up_lvl, ref_lvl, estop_lvl, fault_lvl})
  );
  assign nif.poll_valid    = node_poll_valid_in;
  assign nif.poll_addr     = node_poll_addr_in; // R18
  assign nif.poll_answered = node_poll_answered_in;
  mcs_node_track u_track (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .nif      (nif)
  );
  function automatic logic lamp(input mcs_led_e mode, input logic blink);
    case (mode)
      MCS_LED_ON:    lamp = 1'b1;
      MCS_LED_BLINK: lamp = blink;
      MCS_LED_OFF:   lamp = 1'b0;
      default:       lamp = 1'b0;
    endcase
  endfunction
  // Only 32 bits fit; full complements live in the inverted snapshot word
  function automatic logic [31:0] sw_word(input logic [5:0] l, input logic [5:0] u,
                                          input logic [5:0] r, input logic [1:0] e);
    logic [39:0] w;
    w = {~e, ~r, ~u, ~l, e, r, u, l};
    return w[31:0];
  endfunction
  // A read of the fetch register is the host's periodic input fetch
  assign fetch = rd_in && (addr_in == `MCS_ADDR_FETCH);
  always_comb begin
    mcs_led_e fb_mode;
    mcs_led_e ser_mode;
    mcs_led_e err_mode;
    fb_mode  = MCS_LED_OFF;
    ser_mode = MCS_LED_OFF;
    err_mode = MCS_LED_OFF;
    st_next  = st_reg;
    st_next.rdata = '0;
    if (wr_in) begin
      case (addr_in)
        `MCS_ADDR_CTRL: begin
          st_next.wd_en   = wdata_in[`MCS_CTRL_WD_EN]; // R4
          st_next.pwr_req = wdata_in[`MCS_CTRL_PWR_REQ];
          st_next.running = wdata_in[`MCS_CTRL_RUNNING];
          st_next.booted  = wdata_in[`MCS_CTRL_BOOTED];
          st_next.bus_err = wdata_in[`MCS_CTRL_BUS_ERR];
          // Disabling clears expiry; power cannot return on its own
          if (!wdata_in[`MCS_CTRL_WD_EN]) begin
            st_next.expired = 1'b0; // R20
          end
        end
        `MCS_ADDR_TIMEOUT: st_next.timeout = wdata_in; // R5
        default: ;
      endcase
    end
    // Watchdog counting
    // Placed after the control write so an expiry beats a disabling write
    if (!st_reg.wd_en || fetch) begin
      st_next.wd_cnt = '0; // R1
    end else if (!st_reg.expired) begin
      if (st_reg.wd_cnt >= st_reg.timeout) begin
        st_next.expired = 1'b1; // R20
      end else begin
        st_next.wd_cnt = st_reg.wd_cnt + 32'h1;
      end
    end
    // Switches latched on each fetch, as the host sees one snapshot
    if (fetch) begin
      st_next.low_sw = low_lvl; // R7
      st_next.up_sw  = up_lvl;
      st_next.ref_sw = ref_lvl;
      st_next.estop  = estop_lvl; // R9
    end
    if (rd_in) begin
      case (addr_in)
        `MCS_ADDR_CTRL: st_next.rdata = {27'h0, st_reg.bus_err, st_reg.booted,
                                         st_reg.running, st_reg.pwr_req, st_reg.wd_en};
        `MCS_ADDR_TIMEOUT: st_next.rdata = st_reg.timeout;
        `MCS_ADDR_STATUS: st_next.rdata = {29'h0, fault_lvl, st_reg.amp_en,
                                           st_reg.expired}; // R3
        `MCS_ADDR_FETCH: st_next.rdata = sw_word(low_lvl, up_lvl, ref_lvl, estop_lvl); // R8
        `MCS_ADDR_SWITCH: st_next.rdata = sw_word(st_reg.low_sw, st_reg.up_sw, st_reg.ref_sw,
                                                  st_reg.estop);
        `MCS_ADDR_SWITCH_N: st_next.rdata = {12'h0, ~st_reg.estop, ~st_reg.ref_sw,
                                             ~st_reg.up_sw, ~st_reg.low_sw}; // R8 R9
        `MCS_ADDR_NODES: st_next.rdata = {nif.active, nif.present};
        `MCS_ADDR_LINK: st_next.rdata = {29'h0, nif.dropped, nif.init_busy,
                                         st_reg.fb_traffic};
        default: st_next.rdata = '0;
      endcase
    end
    // Blink base; traffic seen within a period keeps the fieldbus lamp blinking
    if (st_reg.blink_cnt >= 32'(`MCS_BLINK_CYC - 1)) begin
      st_next.blink_cnt  = '0;
      st_next.blink      = ~st_reg.blink;
      st_next.fb_traffic = fieldbus_frame_in;
    end else begin
      st_next.blink_cnt = st_reg.blink_cnt + 32'h1;
      if (fieldbus_frame_in) begin
        st_next.fb_traffic = 1'b1;
      end
    end
    if (fieldbus_full_in) begin
      fb_mode = MCS_LED_ON; // R10
    end else if (st_reg.fb_traffic || fieldbus_frame_in) begin
      fb_mode = MCS_LED_BLINK;
    end
    if (nif.init_busy) begin
      ser_mode = MCS_LED_BLINK; // R11
    end else if (!nif.dropped && |nif.present) begin
      ser_mode = MCS_LED_ON;
    end
    if (st_reg.expired) begin
      err_mode = MCS_LED_ON; // R14
    end else if (st_reg.bus_err) begin
      err_mode = MCS_LED_BLINK;
    end
    st_next.led_fb   = lamp(fb_mode, st_reg.blink);
    st_next.led_ser  = lamp(ser_mode, st_reg.blink);
    st_next.led_run  = st_reg.running & st_reg.blink; // R12
    st_next.led_boot = st_reg.booted; // R13
    st_next.led_err  = lamp(err_mode, st_reg.blink);
    // Enable drops in hardware, no host write needed
    st_next.amp_en = st_next.pwr_req && !st_next.expired && !fault_lvl; // R2 R19
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_reg         <= '0;
      st_reg.timeout <= `MCS_TIMEOUT_RST;
    end else begin
      st_reg <= st_next;
    end
  end
  assign rdata_out            = st_reg.rdata;
  assign amp_enable_out       = st_reg.amp_en;
  assign fieldbus_led_out     = st_reg.led_fb;
  assign serial_led_out       = st_reg.led_ser;
  assign host_running_led_out = st_reg.led_run;
  assign boot_led_out         = st_reg.led_boot;
  assign error_led_out        = st_reg.led_err;

  sequence wd_overrun_s;
    st_reg.wd_en && !st_reg.expired && !fetch && st_reg.wd_cnt >= st_reg.timeout
    && !(wr_in && addr_in == `MCS_ADDR_CTRL);
  endsequence
  sequence wd_dead_s;
    st_reg.expired ##1 !amp_enable_out;
  endsequence
  AST_WD_EXPIRES: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
    wd_overrun_s |=> st_reg.expired)
    else $error("Watchdog did not expire at timeout");
  AST_AMP_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R2
    wd_overrun_s |=> wd_dead_s)
    else $error("Amplifier enable not dropped on expiry");
  AST_FETCH_RESTART: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
    fetch |=> st_reg.wd_cnt == 32'h0)
    else $error("Fetch did not restart watchdog");
  AST_WD_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
    !st_reg.wd_en |=> !st_reg.expired || $past(st_reg.expired))
    else $error("Disabled watchdog expired");
  AST_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R20
    st_reg.expired && !(wr_in && addr_in == `MCS_ADDR_CTRL) |=> st_reg.expired)
    else $error("Expiry cleared without re-enable");
  AST_ENABLE_GATE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R19
    amp_enable_out |-> st_reg.pwr_req && !st_reg.expired)
    else $error("Amplifier enabled without permission");
  AST_SAMPLE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    fetch |=> st_reg.low_sw == $past(low_lvl) && st_reg.ref_sw == $past(ref_lvl))
    else $error("Switches not sampled on fetch");
  AST_ERR_LAMP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R14
    st_reg.expired |=> error_led_out)
    else $error("Error lamp dark after expiry");
  AST_BOOT_LAMP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R13
    !st_reg.booted |=> !boot_led_out)
    else $error("Boot lamp lit before boot");

  // Lamp, gate and register checks; each looks one cycle after its cause
  AST_FAULT_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R19
    fault_lvl |=> !amp_enable_out)
    else $error("Amplifier enabled during power fault");
  AST_ENABLE_ON: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R19
    st_reg.pwr_req && !st_reg.expired && !st_reg.wd_en && !fault_lvl && !wr_in
    |=> amp_enable_out)
    else $error("Amplifier enable withheld");
  AST_RUN_DARK: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
    !st_reg.running |=> !host_running_led_out)
    else $error("Running lamp lit while host idle");
  AST_RUN_GATE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
    host_running_led_out |-> $past(st_reg.running))
    else $error("Running lamp lit without running bit");
  AST_FB_FULL: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
    fieldbus_full_in |=> fieldbus_led_out)
    else $error("Fieldbus lamp dark with buffer full");
  AST_FB_DARK: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
    !fieldbus_full_in && !fieldbus_frame_in && !st_reg.fb_traffic |=> !fieldbus_led_out)
    else $error("Fieldbus lamp lit without traffic");
  AST_SER_DROP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R11
    !nif.init_busy && nif.dropped |=> !serial_led_out)
    else $error("Serial lamp lit after node drop");
  AST_SER_UP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R11
    !nif.init_busy && !nif.dropped && |nif.present |=> serial_led_out)
    else $error("Serial lamp dark with all nodes up");
  AST_ERR_DARK: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R14
    !st_reg.expired && !st_reg.bus_err |=> !error_led_out)
    else $error("Error lamp lit without fault");
  AST_BOOT_ON: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R13
    st_reg.booted |=> boot_led_out)
    else $error("Boot lamp dark after boot");
  AST_TIMEOUT_WR: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
    wr_in && addr_in == `MCS_ADDR_TIMEOUT |=> st_reg.timeout == $past(wdata_in))
    else $error("Timeout write not taken");
  AST_CTRL_WR: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
    wr_in && addr_in == `MCS_ADDR_CTRL |=> st_reg.wd_en == $past(wdata_in[`MCS_CTRL_WD_EN]))
    else $error("Watchdog enable write not taken");
  AST_WD_COUNT: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
    st_reg.wd_en && !st_reg.expired && !fetch && st_reg.wd_cnt < st_reg.timeout
    |=> st_reg.wd_cnt == $past(st_reg.wd_cnt) + 32'h1)
    else $error("Watchdog count did not advance");
  AST_NO_EXPIRE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
    st_reg.wd_en && !st_reg.expired && st_reg.wd_cnt < st_reg.timeout |=> !st_reg.expired)
    else $error("Watchdog expired before timeout");
  AST_SNAP_STOP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    fetch |=> st_reg.estop == $past(estop_lvl) && st_reg.up_sw == $past(up_lvl))
    else $error("Stop inputs not sampled on fetch");
endmodule

//--- bench/mcs_host_model.sv
// Host driver model: register cycles and periodic input fetch
`timescale 1ns/1ps
`include "mcs_consts.svh"
module mcs_host_model (
  input  wire logic                   clk_in,
  output logic      [`MCS_ADDR_W-1:0] addr_out,
  output logic      [`MCS_DATA_W-1:0] wdata_out,
  output logic                        wr_out,
  output logic                        rd_out,
  input  wire logic [`MCS_DATA_W-1:0] rdata_in
);
  initial begin
    addr_out  = '0;
    wdata_out = '0;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    #1 d = rdata_in;
  endtask
  // One fetch every period minus one cycles keeps the watchdog quiet
  task automatic servo(input int period, input int n);
    logic [31:0] d;
    repeat (n) begin
      rd(`MCS_ADDR_FETCH, d);
      repeat (period - 3) @(posedge clk_in);
    end
  endtask
  // Timeout three servo periods, so one late fetch is tolerated
  task automatic arm(input int period);
    wr(`MCS_ADDR_TIMEOUT, 32'(3 * period));
  endtask
endmodule

//--- bench/mcs_supervisor_tb_top.sv
// Self-checking bench for the motion card supervisor
`timescale 1ns/1ps
`include "mcs_consts.svh"
module mcs_supervisor_tb_top;
  localparam int LIMIT = 20000;
  logic        clk_in = 1'b0;
  logic        rst_n_in;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [31:0] rdata;
  logic [5:0]  lo, up, rf;
  logic [1:0]  es;
  logic        pf, fb_frame, fb_full, pv, pans;
  logic [3:0]  paddr;
  logic        amp, fb_led, ser_led, run_led, boot_led, err_led;
  logic [31:0] rv, e_old;
  int          errors, compares, cycles, period, tmo, a;

  always #5 clk_in = ~clk_in;

  mcs_host_model mcs_host_model_inst (
    .clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr_s),
    .rd_out(rd_s), .rdata_in(rdata));

  mcs_supervisor mcs_supervisor_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
    .lower_travel_switch_pin_in(lo), .upper_travel_switch_pin_in(up),
    .reference_switch_pin_in(rf), .estop_pin_in(es), .power_fault_pin_in(pf),
    .fieldbus_frame_in(fb_frame), .fieldbus_full_in(fb_full),
    .node_poll_valid_in(pv), .node_poll_addr_in(paddr),
    .node_poll_answered_in(pans), .amp_enable_out(amp), .fieldbus_led_out(fb_led),
    .serial_led_out(ser_led), .host_running_led_out(run_led),
    .boot_led_out(boot_led), .error_led_out(err_led));

  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic rd(input logic [3:0] ad);
    mcs_host_model_inst.rd(ad, rv);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic poll(input logic [3:0] ad, input logic ans);
    @(posedge clk_in);
    pv    <= 1'b1;
    paddr <= ad;
    pans  <= ans;
    @(posedge clk_in);
    pv    <= 1'b0;
  endtask

  // Fetch word: true states, then complements cut at bit 31
  function automatic logic [31:0] exp_sw(input logic [5:0] l, u, r, input logic [1:0] e);
    logic [39:0] w;
    w = {~e, ~r, ~u, ~l, e, r, u, l};
    return w[31:0];
  endfunction

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(50));
    period = 20 + ($urandom % 21);
    tmo = 3 * period;
    {rst_n_in, lo, up, rf, es, pf, fb_frame, fb_full, pv, pans, paddr} = '0;
    wt(2);
    rst_n_in <= 1'b1;
    wt(4);
    rd(`MCS_ADDR_CTRL);
    chk(rv, 32'h0000_0000, "ctrl reset");
    rd(`MCS_ADDR_TIMEOUT);
    chk(rv, `MCS_TIMEOUT_RST, "timeout reset");
    chk({amp, fb_led, ser_led, run_led, boot_led, err_led}, 32'h0, "lamps");
    mcs_host_model_inst.wr(4'hA, $urandom);
    rd(4'hA);
    chk(rv, 32'h0000_0000, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      lo <= 6'($urandom);
      up <= 6'($urandom);
      rf <= 6'($urandom);
      es <= 2'(i);
      wt(8);
      if (i > 0) begin
        rd(`MCS_ADDR_SWITCH);
        chk(rv, e_old, "snapshot held");
      end
      e_old = exp_sw(lo, up, rf, es);
      rd(`MCS_ADDR_FETCH);
      chk(rv, e_old, "live switches");
      rd(`MCS_ADDR_SWITCH);
      chk(rv, e_old, "snapshot taken");
      rd(`MCS_ADDR_SWITCH_N);
      chk(rv, {12'h0, ~es, ~rf, ~up, ~lo}, "inverted snapshot");
    end
    mcs_host_model_inst.arm(period);
    rd(`MCS_ADDR_TIMEOUT);
    chk(rv, 32'(tmo), "timeout readback");
    mcs_host_model_inst.wr(`MCS_ADDR_CTRL, 32'h0000_000B);
    mcs_host_model_inst.servo(period, 6);
    rd(`MCS_ADDR_STATUS);
    chk(rv[1:0], 2'b10, "fed watchdog");
    chk({amp, boot_led, run_led}, 3'b110, "enable and lamps");
    @(posedge clk_in);
    pf <= 1'b1;
    wt(8);
    chk(amp, 1'b0, "fault drops enable");
    rd(`MCS_ADDR_STATUS);
    chk(rv[2], 1'b1, "fault flag");
    @(posedge clk_in);
    pf <= 1'b0;
    mcs_host_model_inst.servo(period, 2);
    chk(amp, 1'b1, "enable back");
    wt(tmo + 10);
    chk({amp, err_led}, 2'b01, "overrun");
    rd(`MCS_ADDR_STATUS);
    chk(rv[1:0], 2'b01, "expired flag");
    mcs_host_model_inst.servo(period, 2);
    rd(`MCS_ADDR_STATUS);
    chk(rv[1:0], 2'b01, "expiry sticks");
    mcs_host_model_inst.wr(`MCS_ADDR_CTRL, 32'h0000_000A);
    wt(tmo + 10);
    rd(`MCS_ADDR_STATUS);
    chk(rv[1:0], 2'b10, "watchdog off");
    mcs_host_model_inst.wr(`MCS_ADDR_CTRL, 32'h0000_0008);
    @(posedge clk_in);
    fb_full <= 1'b1;
    wt(4);
    chk(fb_led, 1'b1, "buffer full lamp");
    fb_full <= 1'b0;
    fb_frame <= 1'b1;
    @(posedge clk_in);
    fb_frame <= 1'b0;
    rd(`MCS_ADDR_LINK);
    chk(rv[0], 1'b1, "traffic seen");
    for (int n = 0; n < 16; n++) begin
      poll(4'(n), 1'b1);
    end
    wt(4);
    rd(`MCS_ADDR_NODES);
    chk(rv, 32'hFFFF_FFFF, "all nodes found");
    chk(ser_led, 1'b1, "serial lamp up");
    a = $urandom % 16;
    // Silent node: three unanswered polls keep it active, the fourth drops it
    repeat (3) poll(4'(a), 1'b0);
    wt(2);
    rd(`MCS_ADDR_NODES);
    chk(rv[16 + a], 1'b1, "three misses kept");
    poll(4'(a), 1'b0);
    wt(4);
    rd(`MCS_ADDR_NODES);
    chk(rv, {~(16'h0001 << a), 16'hFFFF}, "node dropped");
    rd(`MCS_ADDR_LINK);
    chk(rv[2], 1'b1, "dropped flag");
    chk(ser_led, 1'b0, "serial lamp dark");
    report_and_stop();
  end
endmodule
